// ==== logic/bmd_decoder.sv ====
// board memory address decoder with select, byte lanes and wait timing
`timescale 1ns/1ps
// Operation
// - The decode uses all 20 address bits and anything not on board goes to the system bus.
// - Word and byte transfers are accepted everywhere with byte lanes from size and address.
// - Without expansion the ram select covers 0 to 1FFF.
// - With expansion the ram select covers 0 to 3FFF.
// - Without expansion the eprom window ends at FFFFF and starts by size at FE000 to F0000.
// - With expansion the eprom window starts by size at FC000 to E0000.
// - Ram accesses run with no wait states, a 150 ns cycle.
// - Eprom accesses take configurable wait states for a 200 to 450 ns cycle.
// - Two sockets may hold static ram in the lower half of the eprom window.
module bmd_decoder (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic reqStart,
  input wire logic [19:0] reqAddr,
  input wire logic reqWord,
  input wire logic expFitted,
  input wire logic [1:0] romSize,
  input wire logic ramSockets,
  input wire logic [2:0] romWait,
  output logic selRam,
  output logic selRom,
  output logic selSockRam,
  output logic selSysBus,
  output logic laneLow_b,
  output logic laneHigh_b,
  output logic accReady,
  output logic busy
);
  typedef struct packed {
    bmd_pkg::bmd_st_t st;
    logic [6:0] cnt;
    logic selRam;
    logic selRom;
    logic selSockRam;
    logic selSysBus;
    logic laneLow_b;
    logic laneHigh_b;
    logic accReady;
    logic busy;
    logic expMeta;
    logic expSync;
    logic [1:0] romSizeMeta;
    logic [1:0] romSizeSync;
    logic sockMeta;
    logic sockSync;
    logic [2:0] waitMeta;
    logic [2:0] waitSync;
  } bmd_state_t;

  bmd_state_t s, next_s;
  logic hitRam, hitRom, hitSockRam;
  logic [2:0] waitClamp;

  bmd_window u_window (
    .addr(reqAddr),
    .expFitted(s.expSync),
    .romSize(s.romSizeSync),
    .ramSockets(s.sockSync),
    .hitRam(hitRam),
    .hitRom(hitRom),
    .hitSockRam(hitSockRam)
  );

  function automatic logic [6:0] romCycles(input logic [2:0] w);
    romCycles = 7'(bmd_pkg::ROM_CNT_MIN + 7'(w) * bmd_pkg::STEP_CNT);
  endfunction

  always_comb begin
    next_s = s;
    next_s.accReady = 1'b0;
    // straps are jumpers off the clock domain, two flops before any use
    next_s.expMeta = expFitted;
    next_s.expSync = s.expMeta;
    next_s.romSizeMeta = romSize;
    next_s.romSizeSync = s.romSizeMeta;
    next_s.sockMeta = ramSockets;
    next_s.sockSync = s.sockMeta;
    next_s.waitMeta = romWait;
    next_s.waitSync = s.waitMeta;
    waitClamp = (s.waitSync > bmd_pkg::ROM_WAIT_MAX) ? bmd_pkg::ROM_WAIT_MAX : s.waitSync;
    case (s.st)
      bmd_pkg::BMD_IDLE: begin
        if (reqStart) begin
          next_s.st = bmd_pkg::BMD_BUSY;
          next_s.selRam = hitRam;
          next_s.selRom = hitRom;
          next_s.selSockRam = hitSockRam;
          next_s.selSysBus = !(hitRam || hitRom || hitSockRam);
          next_s.laneLow_b = !(reqWord || !reqAddr[0]);
          next_s.laneHigh_b = !(reqWord || reqAddr[0]);
          if (hitRom) begin
            next_s.cnt = romCycles(waitClamp) - 7'h01;
          end else begin
            next_s.cnt = bmd_pkg::RAM_CNT - 7'h01;
          end
        end
      end
      bmd_pkg::BMD_BUSY: begin
        if (s.cnt == 7'h00) begin
          next_s.st = bmd_pkg::BMD_DONE;
          next_s.accReady = 1'b1;
        end else begin
          next_s.cnt = s.cnt - 7'h01;
        end
      end
      bmd_pkg::BMD_DONE: begin
        next_s.st = bmd_pkg::BMD_IDLE;
        next_s.selRam = 1'b0;
        next_s.selRom = 1'b0;
        next_s.selSockRam = 1'b0;
        next_s.selSysBus = 1'b0;
        next_s.laneLow_b = 1'b1;
        next_s.laneHigh_b = 1'b1;
      end
      default: next_s.st = bmd_pkg::BMD_IDLE;
    endcase
    next_s.busy = (next_s.st != bmd_pkg::BMD_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s <= '{st: bmd_pkg::BMD_IDLE, cnt: 7'h00, selRam: 1'h0, selRom: 1'h0,
             selSockRam: 1'h0, selSysBus: 1'h0, laneLow_b: 1'h1, laneHigh_b: 1'h1,
             accReady: 1'h0, busy: 1'h0, expMeta: 1'h0, expSync: 1'h0,
             romSizeMeta: 2'h0, romSizeSync: 2'h0, sockMeta: 1'h0, sockSync: 1'h0,
             waitMeta: 3'h0, waitSync: 3'h0};
    end else begin
      s <= next_s;
    end
  end

  assign selRam = s.selRam;
  assign selRom = s.selRom;
  assign selSockRam = s.selSockRam;
  assign selSysBus = s.selSysBus;
  assign laneLow_b = s.laneLow_b;
  assign laneHigh_b = s.laneHigh_b;
  assign accReady = s.accReady;
  assign busy = s.busy;

  property p_ram_base;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && !s.expSync && reqAddr == 20'h0_2000)
      |=> !selRam;
  endproperty
  a_ram_base: assert property (p_ram_base) else $error("ram select past 1FFF");

  property p_ram_exp;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && s.expSync && reqAddr == 20'h0_3FFF)
      |=> selRam;
  endproperty
  a_ram_exp: assert property (p_ram_exp) else $error("ram select missing at 3FFF");

  property p_rom_base;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && !s.expSync && !s.sockSync
       && s.romSizeSync == 2'h0) |=> (selRom == ($past(reqAddr) >= 20'hF_E000));
  endproperty
  a_rom_base: assert property (p_rom_base) else $error("8K eprom window wrong");

  property p_rom_exp;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && s.expSync && !s.sockSync
       && s.romSizeSync == 2'h3) |=> (selRom == ($past(reqAddr) >= 20'hE_0000));
  endproperty
  a_rom_exp: assert property (p_rom_exp) else $error("128K eprom window wrong");

  property p_ram_time;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && hitRam) |-> ##31 accReady;
  endproperty
  a_ram_time: assert property (p_ram_time) else $error("ram cycle not 150 ns");

  property p_rom_time;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && hitRom) |-> ##[41:91] accReady;
  endproperty
  a_rom_time: assert property (p_rom_time) else $error("eprom cycle out of range");

  property p_rom_early;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && hitRom) |-> ##40 !accReady;
  endproperty
  a_rom_early: assert property (p_rom_early) else $error("eprom cycle below 200 ns");

  property p_lanes;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && !reqWord && reqAddr[0])
      |=> (laneLow_b && !laneHigh_b);
  endproperty
  a_lanes: assert property (p_lanes) else $error("odd byte lanes wrong");

  property p_even_lane;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && !reqWord && !reqAddr[0])
      |=> (!laneLow_b && laneHigh_b);
  endproperty
  a_even_lane: assert property (p_even_lane) else $error("even byte lanes wrong");

  property p_word_lanes;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && reqWord) |=> (!laneLow_b && !laneHigh_b);
  endproperty
  a_word_lanes: assert property (p_word_lanes) else $error("word lanes wrong");

  property p_sysbus;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && reqAddr > 20'h0_3FFF && reqAddr < 20'hE_0000)
      |=> (selSysBus && !(selRam || selRom || selSockRam));
  endproperty
  a_sysbus: assert property (p_sysbus) else $error("system bus with on-board select");

  property p_sock;
    @(posedge clk_sys) disable iff (!rst_b)
      (s.st == bmd_pkg::BMD_IDLE && reqStart && s.sockSync && !s.expSync
       && s.romSizeSync == 2'h3 && reqAddr >= 20'hF_0000 && reqAddr < 20'hF_8000)
      |=> (selSockRam && !selRom);
  endproperty
  a_sock: assert property (p_sock) else $error("socket ram and eprom both selected");

  property p_ready_pulse;
    @(posedge clk_sys) disable iff (!rst_b)
      accReady |=> !accReady;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

  property p_idle_quiet;
    @(posedge clk_sys) disable iff (!rst_b)
      !busy |-> (!(selRam || selRom || selSockRam || selSysBus) && laneLow_b && laneHigh_b);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("select left on while idle");
endmodule // bmd_decoder

// ==== logic/bmd_pkg.sv ====
// package of constants and types for the board memory address decoder
package bmd_pkg;
  localparam int ADDR_W = 20;
  localparam logic [19:0] RAM_TOP_BASE = 20'h0_1FFF;
  localparam logic [19:0] RAM_TOP_EXP = 20'h0_3FFF;
  localparam logic [19:0] ROM_START_8K = 20'hF_E000;
  localparam logic [19:0] ROM_START_16K = 20'hF_C000;
  localparam logic [19:0] ROM_START_32K = 20'hF_8000;
  localparam logic [19:0] ROM_START_64K = 20'hF_0000;
  localparam logic [19:0] ROM_START_128K = 20'hE_0000;
  // sockets holding static ram are the lower half of the eprom window
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RAM_CYCLE_NS = 150;
  localparam int ROM_CYCLE_MIN_NS = 200;
  localparam int ROM_CYCLE_MAX_NS = 450;
  localparam int RAM_CYCLES = (RAM_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ROM_CYCLES_MIN = (ROM_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ROM_CYCLES_MAX = (ROM_CYCLE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int WAIT_STEP_NS = 50;
  localparam int WAIT_STEP_CYCLES = (WAIT_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] ROM_WAIT_MAX = 3'h5;
  localparam logic [6:0] RAM_CNT = 7'(RAM_CYCLES);
  localparam logic [6:0] ROM_CNT_MIN = 7'(ROM_CYCLES_MIN);
  localparam logic [6:0] STEP_CNT = 7'(WAIT_STEP_CYCLES);
  typedef enum logic [1:0] {BMD_ROM_8K, BMD_ROM_16K, BMD_ROM_32K, BMD_ROM_64K} bmd_size_t;
  typedef enum logic [1:0] {BMD_IDLE, BMD_BUSY, BMD_DONE} bmd_st_t;
endpackage

// ==== logic/bmd_window.sv ====
// combinational window decode of one physical address
`timescale 1ns/1ps
module bmd_window (
  input wire logic [19:0] addr,
  input wire logic expFitted,
  input wire logic [1:0] romSize,
  input wire logic ramSockets,
  output logic hitRam,
  output logic hitRom,
  output logic hitSockRam
);
  logic [19:0] romStart;
  logic [19:0] sockSplit;
  always_comb begin
    // expansion doubles every eprom size, so each step starts one size lower
    case ({expFitted, romSize})
      3'b000: romStart = bmd_pkg::ROM_START_8K;
      3'b001, 3'b100: romStart = bmd_pkg::ROM_START_16K;
      3'b010, 3'b101: romStart = bmd_pkg::ROM_START_32K;
      3'b011, 3'b110: romStart = bmd_pkg::ROM_START_64K;
      default: romStart = bmd_pkg::ROM_START_128K;
    endcase
    sockSplit = romStart + ((~romStart + 20'h0_0001) >> 1);
    hitRam = addr <= (expFitted ? bmd_pkg::RAM_TOP_EXP : bmd_pkg::RAM_TOP_BASE);
    hitSockRam = ramSockets && addr >= romStart && addr < sockSplit;
    hitRom = addr >= romStart && !hitSockRam;
  end
endmodule // bmd_window

// ==== sim/bmd_bus_master.sv ====
// bus master model that issues decoder accesses and times their completion
`timescale 1ns/1ps
module bmd_bus_master (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic accReady,
  output logic reqStart,
  output logic [19:0] reqAddr,
  output logic reqWord
);
  initial begin
    reqStart = 1'b0;
    reqAddr = 20'h0_0000;
    reqWord = 1'b0;
  end
  // lat counts edges from the take edge to the one raising accReady
  task automatic access(input logic [19:0] a, input logic w, output int lat);
    lat = 0;
    while (busy !== 1'b0) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    reqStart <= 1'b1;
    reqAddr <= a;
    reqWord <= w;
    @(posedge clk_sys);
    reqStart <= 1'b0;
    // released lines show the inverse, not the old value
    reqAddr <= ~a;
    reqWord <= ~w;
    do begin
      @(posedge clk_sys);
      #1;
      lat++;
    end while (accReady !== 1'b1 && lat < 200);
  endtask
endmodule // bmd_bus_master

// ==== sim/tb_top.sv ====
// self-checking testbench for the board memory address decoder
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic reqStart, reqWord, expFitted = 1'b0, ramSockets = 1'b0;
  logic [19:0] reqAddr;
  logic [1:0] romSize = 2'h0;
  logic [2:0] romWait = 3'h0;
  logic selRam, selRom, selSockRam, selSysBus, laneLow_b, laneHigh_b, accReady, busy;
  int n_mismatch = 0;
  int check_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  bmd_decoder uut (.clk_sys(clk_sys), .rst_b(rst_b), .reqStart(reqStart), .reqAddr(reqAddr),
    .reqWord(reqWord), .expFitted(expFitted), .romSize(romSize), .ramSockets(ramSockets),
    .romWait(romWait), .selRam(selRam), .selRom(selRom), .selSockRam(selSockRam),
    .selSysBus(selSysBus), .laneLow_b(laneLow_b), .laneHigh_b(laneHigh_b),
    .accReady(accReady), .busy(busy));
  bmd_bus_master mdl (.clk_sys(clk_sys), .busy(busy), .accReady(accReady),
    .reqStart(reqStart), .reqAddr(reqAddr), .reqWord(reqWord));
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    check_count++;
    if (seen !== expd) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // sel order is ram, rom, socket ram, system bus
  task automatic acc(input logic [19:0] a, input logic w, input logic [3:0] sel, input int lat);
    int seen;
    mdl.access(a, w, seen);
    check(32'(seen), 32'(lat));
    check({28'h0, selRam, selRom, selSockRam, selSysBus}, {28'h0, sel});
    check({30'h0, laneHigh_b, laneLow_b}, {30'h0, w ? 2'b00 : (a[0] ? 2'b01 : 2'b10)});
  endtask
  task automatic cfg(input logic e, input logic [1:0] s, input logic k, input logic [2:0] wt);
    @(posedge clk_sys);
    expFitted <= e;
    romSize <= s;
    ramSockets <= k;
    romWait <= wt;
    // straps pass a two-stage synchroniser before the decode sees them
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_ram;
    cfg(1'b0, 2'h0, 1'b0, 3'h0);
    acc(20'h0_1FFF, 1'b0, 4'b1000, 30);
    acc(20'h0_2000, 1'b1, 4'b0001, 30);
    cfg(1'b1, 2'h0, 1'b0, 3'h0);
    acc(20'h0_3FFF, 1'b1, 4'b1000, 30);
    acc(20'h0_4000, 1'b0, 4'b0001, 30);
    $display("test ram windows done");
  endtask
  task automatic t_rom;
    logic [19:0] base;
    for (int e = 0; e < 2; e++) begin
      for (int s = 0; s < 4; s++) begin
        base = 20'(21'h10_0000 - (21'h00_2000 << (s + e)));
        cfg(e[0], s[1:0], 1'b0, 3'(s + e));
        acc(base, 1'b0, 4'b0100, 40 + 10 * (s + e));
        acc(base - 20'h0_0001, 1'b0, 4'b0001, 30);
      end
    end
    cfg(1'b0, 2'h0, 1'b0, 3'h7);
    acc(20'hF_FFFF, 1'b0, 4'b0100, 90);
    $display("test eprom windows done");
  endtask
  task automatic t_sock;
    cfg(1'b0, 2'h3, 1'b1, 3'h2);
    acc(20'hF_0000, 1'b1, 4'b0010, 30);
    acc(20'hF_7FFF, 1'b0, 4'b0010, 30);
    acc(20'hF_8000, 1'b1, 4'b0100, 60);
    $display("test socket ram done");
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({27'h0, selRam, selRom, selSockRam, selSysBus, busy}, 32'h0000_0000);
    t_ram();
    t_rom();
    t_sock();
    tally_and_finish();
  end
endmodule // tb_top
